// ===== rtl/gbc_pkg.sv
// Constants, types and carriers for the gated burst controller.
//
// What this block does
// - In gated mode oscillation starts once an active gate level is accepted.
// - Whole-period stop: after gate release run on until phase reaches the start/stop angle.
// - Half-period stop: halt at angle or angle plus 180 degrees, then settle to angle.
// - Internal source makes the gate as a 50% square wave of programmable period.
// - External source gets a programmable polarity; off polarity blocks the input.
// - Channel two may use the gate source that channel one has chosen.
// - Manual key and remote gating work whatever source is selected.
// - In gated run mode the gate stays on while the manual key is held on the displayed channel.
// - The trigger-seen lamp is lit for the whole time the gate is on.
// - Gated modes ignore the trigger delay and use only the fixed minimum delay.
// - Gated operation is refused when the waveform is DC.
// - Noise runs exactly while the gate is on, unaligned, and idles otherwise.
// - Burst activity selection drives sync low while running and high while stopped.
// - Disabled auxiliary selection holds the sync output low.
// - Reference phase selection gives a rising edge at the waveform reference phase.
// - Secondary waveform output is allowed only with modulation off or external.
// - Modulation sync and waveform outputs are allowed only with internal modulation on.
// - Entering a gated mode forcibly ends active multi-unit phase synchronization.
// - Toggled gate mode inverts the internal gate on each accepted trigger.
// - Stopped output is the start/stop angle level, or a percentage when overridden.
// - External source takes the gate from the logic-level external trigger input.
package gbc_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          PHASE_W    = 16;
    localparam int          PERIOD_W   = 32;
    localparam int          PCT_W      = 8;
    localparam int          SYNC_W     = 2;
    localparam int          DLY_W      = 16;
    localparam logic [15:0] PHASE_HALF = 16'h8000;
    localparam logic [15:0] PHASE_RST  = 16'h0000;
    localparam logic [31:0] CNT_RST    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CONTINUOUS_MODE           = 2'b00,
        GATED_RUN_MODE            = 2'b01,
        TRIGGER_TOGGLED_GATE_MODE = 2'b10
    } gbc_mode_type;

    typedef enum logic [0:0] {
        WHOLE_PERIOD_UNIT = 1'b0,
        HALF_PERIOD_UNIT  = 1'b1
    } gbc_gran_type;

    typedef enum logic [1:0] {
        INTERNAL_SOURCE             = 2'b00,
        EXTERNAL_SOURCE             = 2'b01,
        SHARED_FIRST_CHANNEL_SOURCE = 2'b10
    } gbc_src_type;

    typedef enum logic [1:0] {
        POLARITY_OFF      = 2'b00,
        POLARITY_POSITIVE = 2'b01,
        POLARITY_NEGATIVE = 2'b10
    } gbc_pol_type;

    typedef enum logic [2:0] {
        AUX_DISABLED                = 3'b000,
        REFERENCE_PHASE_PULSE       = 3'b001,
        BURST_ACTIVITY_FLAG         = 3'b010,
        SECONDARY_WAVEFORM_OUT      = 3'b011,
        MODULATION_SYNC_PULSE       = 3'b100,
        MODULATION_WAVEFORM_OUT     = 3'b101
    } gbc_aux_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DRAIN = 2'b10
    } gbc_state_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        gbc_mode_type         burst_mode_select;
        gbc_gran_type         stop_granularity;
        gbc_src_type          trigger_source_select;
        gbc_pol_type          ext_polarity;
        logic [PERIOD_W-1:0]  trigger_period;
        logic [PHASE_W-1:0]   start_stop_angle;
        logic [PHASE_W-1:0]   phase_step;
        logic                 wave_is_dc;
        logic                 wave_is_noise;
        logic                 idle_level_override;
        logic [PCT_W-1:0]     idle_level_pct;
        gbc_aux_type          aux_output_select;
        logic                 modulation_on;
        logic                 modulation_internal;
        logic [DLY_W-1:0]     trigger_delay_setting;
        logic                 second_channel;
        logic                 channel_displayed;
    } gbc_cfg_type;

    typedef struct packed {
        logic                 running;
        logic [PHASE_W-1:0]   phase;
        logic                 hold_active;
        logic                 hold_use_pct;
        logic [PCT_W-1:0]     hold_pct;
        logic                 noise_enable;
        logic                 trigger_seen_lamp;
        logic                 sync_out;
        logic                 secondary_wave_en;
        logic                 modulation_wave_en;
        logic                 aux_illegal;
        logic                 gated_refused;
        logic                 multi_sync_stop;
    } gbc_status_type;

endpackage

// ===== rtl/gbc_sync2.sv
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module gbc_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Asynchronous input and synchronised output.
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/gbc_core.sv
// Gated and trigger-toggled burst controller for one generator channel.
`timescale 1ns/1ps
`default_nettype none
module gbc_core (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Configuration.
    input  wire gbc_pkg::gbc_cfg_type   cfg,
    // Gate, trigger and synchronisation inputs.
    input  wire logic                   ext_trigger_pin,
    input  wire logic                   manual_trigger_key,
    input  wire logic                   remote_gate,
    input  wire logic                   first_channel_gate,
    input  wire logic                   modulation_sync_in,
    input  wire logic                   multi_sync_active,
    // Status and waveform control.
    output var  gbc_pkg::gbc_status_type status,
    output var  logic                   internal_gate
);
    import gbc_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Tells whether an auxiliary selection is legal for the modulation setup.
    function automatic logic aux_legal(input gbc_aux_type sel, input logic mod_on, input logic mod_int);
        logic int_mod;
        int_mod = mod_on & mod_int;
        case (sel)
            SECONDARY_WAVEFORM_OUT:  aux_legal = ~int_mod;
            MODULATION_SYNC_PULSE:   aux_legal = int_mod;
            MODULATION_WAVEFORM_OUT: aux_legal = int_mod;
            default:                 aux_legal = 1'b1;
        endcase
    endfunction

    // Tells whether a mode is one of the gated modes.
    function automatic logic is_gated(input gbc_mode_type m);
        is_gated = (m == GATED_RUN_MODE) || (m == TRIGGER_TOGGLED_GATE_MODE);
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [1:0] pin_sync;

    gbc_sync2 #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({manual_trigger_key, ext_trigger_pin}),
        .sync_out (pin_sync)
    );

    // ------------------------------------------------------------------
    // Gate sources
    // ------------------------------------------------------------------
    logic [PERIOD_W-1:0] int_cnt;
    logic [PERIOD_W-1:0] next_int_cnt;
    logic                int_sq;
    logic                next_int_sq;
    logic [PERIOD_W-1:0] half_last;
    logic                ext_level;
    logic                src_gate;
    logic                key_gate;
    logic                raw_gate;
    logic                raw_gate_q;
    logic                trig_edge;
    logic                next_internal_gate;
    logic                gate_eff;
    gbc_mode_type        eff_mode;
    gbc_mode_type        mode_q;
    logic                refused;

    // Builds the gate from the selected source plus the always-on key and remote paths.
    always_comb begin
        half_last    = CNT_RST;
        if (cfg.trigger_period[PERIOD_W-1:1] > 31'h1) begin
            half_last = {1'b0, cfg.trigger_period[PERIOD_W-1:1]} - 32'h1;
        end
        next_int_cnt = (int_cnt >= half_last) ? CNT_RST : int_cnt + 32'h1;
        next_int_sq  = (int_cnt >= half_last) ? ~int_sq : int_sq;
        case (cfg.ext_polarity)
            POLARITY_POSITIVE: ext_level = pin_sync[0];
            POLARITY_NEGATIVE: ext_level = ~pin_sync[0];
            default:           ext_level = 1'b0;
        endcase
        case (cfg.trigger_source_select)
            INTERNAL_SOURCE: src_gate = int_sq;
            EXTERNAL_SOURCE: src_gate = ext_level;
            SHARED_FIRST_CHANNEL_SOURCE: src_gate = cfg.second_channel ? first_channel_gate : 1'b0;
            default: src_gate = 1'b0;
        endcase
        key_gate = pin_sync[1] & cfg.channel_displayed;
        raw_gate = src_gate | key_gate | remote_gate;
    end

    // Mode resolution, trigger edge and toggled gate.
    always_comb begin
        refused            = is_gated(cfg.burst_mode_select) & cfg.wave_is_dc;
        eff_mode           = refused ? CONTINUOUS_MODE : cfg.burst_mode_select;
        trig_edge          = raw_gate & ~raw_gate_q;
        next_internal_gate = (eff_mode == TRIGGER_TOGGLED_GATE_MODE) ? (internal_gate ^ trig_edge) : 1'b0;
        // The gate path has a fixed one-cycle delay; the delay setting is not used here.
        gate_eff           = (eff_mode == TRIGGER_TOGGLED_GATE_MODE) ? internal_gate : raw_gate_q;
    end

    // Registers the gate sources.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_cnt       <= CNT_RST;
            int_sq        <= 1'b0;
            raw_gate_q    <= 1'b0;
            internal_gate <= 1'b0;
            mode_q        <= CONTINUOUS_MODE;
        end else begin
            int_cnt       <= next_int_cnt;
            int_sq        <= next_int_sq;
            raw_gate_q    <= raw_gate;
            internal_gate <= next_internal_gate;
            mode_q        <= cfg.burst_mode_select;
        end
    end

    // ------------------------------------------------------------------
    // Oscillation state and phase
    // ------------------------------------------------------------------
    gbc_state_type        state;
    gbc_state_type        next_state;
    logic [PHASE_W-1:0]   phase;
    logic [PHASE_W-1:0]   next_phase;
    logic [PHASE_W-1:0]   rel;
    logic [PHASE_W:0]     rel_sum;
    logic                 hit_full;
    logic                 hit_half;
    logic                 hit;

    // Decides when to start, when to drain and when the stop angle is reached.
    always_comb begin
        rel        = phase - cfg.start_stop_angle;
        rel_sum    = {1'b0, rel} + {1'b0, cfg.phase_step};
        hit_full   = rel_sum[PHASE_W];
        hit_half   = hit_full | (~rel[PHASE_W-1] & rel_sum[PHASE_W-1] & ~rel_sum[PHASE_W]);
        hit        = (cfg.stop_granularity == HALF_PERIOD_UNIT) ? hit_half : hit_full;
        next_state = state;
        next_phase = phase + cfg.phase_step;
        case (state)
            ST_IDLE: begin
                next_phase = cfg.start_stop_angle;
                if (eff_mode == CONTINUOUS_MODE || gate_eff) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (eff_mode != CONTINUOUS_MODE && !gate_eff) begin
                    next_state = cfg.wave_is_noise ? ST_IDLE : ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (gate_eff || eff_mode == CONTINUOUS_MODE) begin
                    next_state = ST_RUN;
                end else if (hit || cfg.wave_is_noise) begin
                    next_state = ST_IDLE;
                    next_phase = cfg.start_stop_angle;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_phase = cfg.start_stop_angle;
            end
        endcase
    end

    // Registers the state and phase.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            phase <= PHASE_RST;
        end else begin
            state <= next_state;
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    gbc_status_type next_status;
    logic           legal;
    logic           run_next;

    // Computes every output from the next state so they all leave flip-flops.
    always_comb begin
        legal                          = aux_legal(cfg.aux_output_select, cfg.modulation_on, cfg.modulation_internal);
        run_next                       = (next_state != ST_IDLE);
        next_status                    = '0;
        next_status.running            = run_next;
        next_status.phase              = next_phase;
        next_status.hold_active        = ~run_next;
        next_status.hold_use_pct       = ~run_next & cfg.idle_level_override;
        next_status.hold_pct           = cfg.idle_level_pct;
        next_status.noise_enable       = run_next & cfg.wave_is_noise;
        next_status.trigger_seen_lamp  = is_gated(eff_mode) & gate_eff;
        next_status.aux_illegal        = ~legal;
        next_status.gated_refused      = refused;
        next_status.multi_sync_stop    = is_gated(cfg.burst_mode_select) & ~is_gated(mode_q) & multi_sync_active;
        if (legal) begin
            case (cfg.aux_output_select)
                REFERENCE_PHASE_PULSE:   next_status.sync_out = ~next_phase[PHASE_W-1];
                BURST_ACTIVITY_FLAG:     next_status.sync_out = ~run_next;
                MODULATION_SYNC_PULSE:   next_status.sync_out = modulation_sync_in;
                SECONDARY_WAVEFORM_OUT:  next_status.secondary_wave_en = 1'b1;
                MODULATION_WAVEFORM_OUT: next_status.modulation_wave_en = 1'b1;
                default:                 next_status.sync_out = 1'b0;
            endcase
        end
    end

    // Registers the outputs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    gate_start_a: assert property (
        (state == ST_IDLE && eff_mode == GATED_RUN_MODE && gate_eff) |=> (state == ST_RUN) && status.running)
        else $error("gate on did not start oscillation");

    whole_stop_a: assert property (
        (state == ST_DRAIN && eff_mode != CONTINUOUS_MODE && !gate_eff && hit_full
         && cfg.stop_granularity == WHOLE_PERIOD_UNIT) |=> (state == ST_IDLE) && (phase == $past(cfg.start_stop_angle)))
        else $error("whole period stop missed the angle");

    half_stop_a: assert property (
        (state == ST_DRAIN && eff_mode != CONTINUOUS_MODE && !gate_eff && hit_half
         && cfg.stop_granularity == HALF_PERIOD_UNIT) |=> (state == ST_IDLE) ##1 (phase == $past(cfg.start_stop_angle, 2)))
        else $error("half period stop missed the angle");

    int_square_a: assert property (
        (int_cnt >= half_last) |=> (int_sq != $past(int_sq)) && (int_cnt == CNT_RST))
        else $error("internal square did not toggle at half period");

    ext_off_a: assert property (
        (cfg.ext_polarity == POLARITY_OFF) |-> !ext_level)
        else $error("external input passed with polarity off");

    key_gate_a: assert property (
        (pin_sync[1] && cfg.channel_displayed) |=> raw_gate_q)
        else $error("held key did not hold the gate");

    lamp_gate_a: assert property (
        (eff_mode == GATED_RUN_MODE && $past(eff_mode) == GATED_RUN_MODE) |-> ##1 (status.trigger_seen_lamp == $past(gate_eff, 1)))
        else $error("lamp does not follow the gate");

    dc_refuse_a: assert property (
        (cfg.wave_is_dc && is_gated(cfg.burst_mode_select)) |=> status.gated_refused && !status.trigger_seen_lamp)
        else $error("gated operation with DC waveform");

    burst_flag_a: assert property (
        (cfg.aux_output_select == BURST_ACTIVITY_FLAG) |=> (status.sync_out == !status.running))
        else $error("burst flag disagrees with oscillation");

    aux_off_a: assert property (
        (cfg.aux_output_select == AUX_DISABLED) |=> !status.sync_out)
        else $error("sync output not low when disabled");

    sync_kill_a: assert property (
        (cfg.burst_mode_select == GATED_RUN_MODE && mode_q == CONTINUOUS_MODE && multi_sync_active) |=> status.multi_sync_stop)
        else $error("multi-unit sync not terminated");

    toggle_gate_a: assert property (
        (eff_mode == TRIGGER_TOGGLED_GATE_MODE && trig_edge) |=> (internal_gate != $past(internal_gate)))
        else $error("accepted trigger did not invert the gate");

    noise_stop_a: assert property (
        (state == ST_RUN && cfg.wave_is_noise && eff_mode == GATED_RUN_MODE && !gate_eff) |=> !status.running)
        else $error("noise kept running after gate off");

    gated_burst_c: cover property ((state == ST_DRAIN) ##1 (state == ST_IDLE));
    half_stop_c:   cover property ((cfg.stop_granularity == HALF_PERIOD_UNIT && state == ST_DRAIN) ##1 (state == ST_IDLE));
    toggle_c:      cover property ((eff_mode == TRIGGER_TOGGLED_GATE_MODE) && trig_edge && internal_gate);

endmodule
`default_nettype wire

// ===== bench/gbc_gate_model.sv
// Behavioural model of the external gate source and of the sync observer.
`timescale 1ns/1ps
`default_nettype none
module gbc_gate_model (
    // Gate level asked for by the bench.
    input  wire logic level_cmd,
    // Sync line under watch.
    input  wire logic sync_out,
    // Logic-level trigger pin and the count of sync rises.
    output var  logic pin,
    output var  int   sync_rises
);
    // The pin follows the request with a skew that bears no relation to the clock.
    initial pin = 1'b0;
    always @(level_cmd) begin
        pin <= #3 level_cmd;
    end

    // Each rising edge of the sync line is counted.
    initial sync_rises = 0;
    always @(posedge sync_out) begin
        sync_rises <= sync_rises + 1;
    end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the gated burst controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gbc_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic           clk;
    logic           sys_rst;
    gbc_cfg_type    cfg;
    logic           gate_cmd;
    logic           ext_pin;
    logic           key;
    logic           remote_gate;
    logic           first_gate;
    logic           msync;
    logic           mod_sync;
    gbc_status_type status;
    logic           internal_gate;
    int             sync_rises;
    int             fail_count;
    int             check_count;
    int             cycles;
    int             n;

    gbc_core uut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .ext_trigger_pin(ext_pin),
        .manual_trigger_key(key), .remote_gate(remote_gate), .first_channel_gate(first_gate),
        .modulation_sync_in(mod_sync), .multi_sync_active(msync), .status(status),
        .internal_gate(internal_gate));
    gbc_gate_model src (.level_cmd(gate_cmd), .sync_out(status.sync_out), .pin(ext_pin),
        .sync_rises(sync_rises));

    // Clock and a ceiling on the run time.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial cycles = 0;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Waits a bounded time for running to reach a level; n holds the wait.
    task automatic wait_run(input logic v, input int lim);
        n = 0;
        while (status.running !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    // Drops every gate and waits for the block to stop.
    task automatic park();
        @(posedge clk);
        remote_gate <= 1'b0;
        key         <= 1'b0;
        first_gate  <= 1'b0;
        gate_cmd    <= 1'b0;
        wait_run(1'b0, 40);
        tick(2);
        chk(status.hold_active, 1);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_burst(input gbc_gran_type g, input int lim);
        int rises;
        @(posedge clk) cfg.stop_granularity <= g;
        @(posedge clk) remote_gate <= 1'b1;
        tick(1);
        chk(status.running, 0);
        tick(1);
        chk({status.running, status.trigger_seen_lamp, status.sync_out}, 3'b110);
        rises = sync_rises;
        @(posedge clk) remote_gate <= 1'b0;
        wait_run(1'b0, lim);
        chk(n < lim, 1);
        tick(1);
        chk({status.phase, status.hold_active, status.sync_out}, {16'h2000, 2'b11});
        chk(sync_rises - rises, 1);
    endtask
    task automatic t_internal();
        int highs;
        @(posedge clk) cfg.trigger_source_select <= INTERNAL_SOURCE;
        tick(8);
        highs = 0;
        repeat (32) begin
            tick(1);
            highs += (status.trigger_seen_lamp === 1'b1);
        end
        chk(highs, 16);
        @(posedge clk) cfg.trigger_source_select <= EXTERNAL_SOURCE;
        park();
    endtask
    task automatic t_ext();
        @(posedge clk) cfg.ext_polarity <= POLARITY_POSITIVE;
        gate_cmd <= 1'b1;
        wait_run(1'b1, 8);
        chk(n < 8, 1);
        park();
        @(posedge clk) cfg.ext_polarity <= POLARITY_NEGATIVE;
        wait_run(1'b1, 8);
        chk(n < 8, 1);
        @(posedge clk) gate_cmd <= 1'b1;
        wait_run(1'b0, 30);
        chk(n < 30, 1);
        @(posedge clk) cfg.ext_polarity <= POLARITY_OFF;
        tick(10);
        chk(status.running, 0);
        park();
    endtask
    task automatic t_key();
        @(posedge clk) cfg.channel_displayed <= 1'b0;
        cfg.wave_is_noise <= 1'b1;
        key <= 1'b1;
        tick(10);
        chk(status.running, 0);
        @(posedge clk) cfg.channel_displayed <= 1'b1;
        wait_run(1'b1, 8);
        chk({n < 8, status.noise_enable}, 2'b11);
        @(posedge clk) key <= 1'b0;
        wait_run(1'b0, 8);
        tick(1);
        chk({n < 8, status.noise_enable, status.hold_active}, 3'b101);
        @(posedge clk) cfg.wave_is_noise <= 1'b0;
    endtask
    task automatic t_shared();
        @(posedge clk) cfg.trigger_source_select <= SHARED_FIRST_CHANNEL_SOURCE;
        first_gate <= 1'b1;
        tick(10);
        chk(status.running, 0);
        @(posedge clk) cfg.second_channel <= 1'b1;
        wait_run(1'b1, 6);
        chk(n < 6, 1);
        park();
        @(posedge clk) cfg.trigger_source_select <= EXTERNAL_SOURCE;
    endtask
    task automatic t_refuse();
        int rises;
        @(posedge clk) cfg.aux_output_select <= AUX_DISABLED;
        cfg.idle_level_override <= 1'b1;
        cfg.idle_level_pct <= 8'h40;
        tick(4);
        chk({status.sync_out, status.hold_use_pct, status.hold_pct}, {2'b01, 8'h40});
        @(posedge clk) cfg.aux_output_select <= SECONDARY_WAVEFORM_OUT;
        cfg.modulation_on <= 1'b1;
        cfg.modulation_internal <= 1'b1;
        tick(4);
        chk({status.aux_illegal, status.secondary_wave_en}, 2'b10);
        @(posedge clk) cfg.aux_output_select <= MODULATION_SYNC_PULSE;
        mod_sync <= 1'b1;
        tick(3);
        chk({status.aux_illegal, status.sync_out}, 2'b01);
        @(posedge clk) cfg.aux_output_select <= MODULATION_WAVEFORM_OUT;
        tick(3);
        chk({status.aux_illegal, status.modulation_wave_en}, 2'b01);
        @(posedge clk) cfg.wave_is_dc <= 1'b1;
        remote_gate <= 1'b1;
        tick(4);
        chk({status.gated_refused, status.trigger_seen_lamp}, 2'b10);
        @(posedge clk) cfg.aux_output_select <= REFERENCE_PHASE_PULSE;
        tick(3);
        rises = sync_rises;
        tick(64);
        chk(sync_rises - rises, 2);
        @(posedge clk) cfg.wave_is_dc <= 1'b0;
        cfg.aux_output_select <= BURST_ACTIVITY_FLAG;
        cfg.idle_level_override <= 1'b0;
        cfg.modulation_on <= 1'b0;
        park();
    endtask
    task automatic t_toggle();
        int pulses;
        @(posedge clk) cfg.burst_mode_select <= CONTINUOUS_MODE;
        msync <= 1'b1;
        tick(4);
        @(posedge clk) cfg.burst_mode_select <= TRIGGER_TOGGLED_GATE_MODE;
        pulses = 0;
        repeat (6) begin
            tick(1);
            pulses += (status.multi_sync_stop === 1'b1);
        end
        chk(pulses, 1);
        park();
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk) remote_gate <= 1'b1;
            @(posedge clk) remote_gate <= 1'b0;
            tick(2);
            chk(internal_gate, i[0]);
            wait_run(i[0], 30);
            chk(n < 30, 1);
        end
        @(posedge clk) cfg.burst_mode_select <= GATED_RUN_MODE;
        msync <= 1'b0;
    endtask

    // Reset, configuration at time zero and the main sequence.
    initial begin
        fail_count = 0;
        check_count = 0;
        sys_rst = 1'b1;
        gate_cmd = 1'b0;
        key = 1'b0;
        remote_gate = 1'b0;
        first_gate = 1'b0;
        msync = 1'b0;
        mod_sync = 1'b0;
        cfg = '0;
        cfg.burst_mode_select = GATED_RUN_MODE;
        cfg.trigger_source_select = EXTERNAL_SOURCE;
        cfg.trigger_period = 32'h0000_0008;
        cfg.start_stop_angle = 16'h2000;
        cfg.phase_step = 16'h0800;
        cfg.aux_output_select = BURST_ACTIVITY_FLAG;
        cfg.trigger_delay_setting = 16'hffff;
        cfg.channel_displayed = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        park();
        t_burst(WHOLE_PERIOD_UNIT, 36);
        t_burst(HALF_PERIOD_UNIT, 20);
        t_internal();
        t_ext();
        t_key();
        t_shared();
        t_refuse();
        t_toggle();
        wrap_up();
    end
endmodule
`default_nettype wire
